// File: hw/lrd_diag.sv
// Purpose: condition flags, fault detail, speed supervision, zero-point adjust
// Assumes: measurement inputs arrive on core_clk, ack pin is asynchronous
// Notes: one register port, read data one cycle after the read strobe
//
// Overview of operation
// [R01] low intensity or beam cut sets bit0
// [R02] temperature outside 0..50 C sets bit1
// [R03] hardware fault sets bit2, forces error value
// [R04] laser emitter switched off sets bit3
// [R05] intensity under 12 percent sets bit4
// [R06] speed above threshold sets bit5
// [R07] implausible measurement sets bit6
// [R08] four-bit hardware fault detail vector
// [R09] threshold 0 disables, 1..200 in 0.1 m/s
// [R10] switching output on overspeed only when selected
// [R11] smoothing range automatic or three fixed
// [R12] speed unit 1 or 10 mm/s
// [R13] speed unsigned magnitude or signed
// [R14] offset clearing outputs raw, refuses adjust
// [R15] written target position yields zero-point correction
// [R16] error reports optionally latched until acknowledged
// [R17] manual mode clears only on input ack edge
// [R18] error substitute zeros, ones or last valid
// [R19] unused bits zero, flags follow conditions
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "lrd_regs.svh"

module lrd_diag (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // measurement inputs
  input wire logic [6:0] intensity_pct,
  input wire logic beam_interrupted,
  input wire logic signed [7:0] temp_c,
  input wire logic [3:0] hw_fault_in,
  input wire logic laser_off_by_input,
  input wire logic plaus_fail,
  input wire logic [23:0] raw_position,
  input wire logic signed [15:0] speed_mms,
  input wire logic pos_switch_hit,
  // switching input used as error acknowledge
  input wire logic ack_pin,
  // outputs
  output logic [23:0] position_out,
  output logic [15:0] speed_out,
  output logic [1:0] dyn_range,
  output logic laser_emitter_off,
  output logic fail_out,
  output logic irq
);
  import lrd_pkg::*;

  lrd_state_s q;
  lrd_state_s d;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
    is_addr = (a == off);
  endfunction

  logic [6:0] live;
  logic [6:0] shown;
  logic err_sub;
  logic ack_edge;
  logic [15:0] speed_abs;
  logic [15:0] limit_mms;
  logic [23:0] adj_pos;
  logic [15:0] scaled;
  lrd_failfn_e fn;
  lrd_errval_e ev;
  lrd_dyn_e dyn;
  logic fail_raw;

  // ****************************************************************
  // combinational next state
  // ****************************************************************
  always_comb begin
    d = q;
    fn = lrd_failfn_e'(q.cfg[`LRD_CFG_FAILFN_MSB:`LRD_CFG_FAILFN_LSB]);
    ev = lrd_errval_e'(q.cfg[`LRD_CFG_ERRVAL_MSB:`LRD_CFG_ERRVAL_LSB]);
    dyn = lrd_dyn_e'(q.cfg[`LRD_CFG_DYN_MSB:`LRD_CFG_DYN_LSB]);
    speed_abs = speed_mms[15] ? 16'(-speed_mms) : speed_mms;
    limit_mms = 16'(q.thresh * `LRD_MMS_PER_STEP);

    live = 7'h00;
    live[`LRD_BIT_INTENSITY] = (intensity_pct < `LRD_INT_ERR_PCT) || beam_interrupted; // R01
    live[`LRD_BIT_TEMP] = (temp_c < `LRD_TEMP_MIN_C) || (temp_c > `LRD_TEMP_MAX_C); // R02
    live[`LRD_BIT_HARDWARE] = |hw_fault_in; // R03
    live[`LRD_BIT_LASER_OFF] = laser_off_by_input || q.laser_off_cmd; // R04
    live[`LRD_BIT_CLEAN] = intensity_pct < `LRD_INT_WARN_PCT; // R05
    live[`LRD_BIT_OVERSPEED] = (q.thresh != `LRD_THRESH_RESET) && (speed_abs > limit_mms); // R06 R09
    live[`LRD_BIT_PLAUS] = plaus_fail; // R07

    // acknowledge edge from synchronised switching input
    d.ack_sync = {q.ack_sync[1:0], ack_pin};
    ack_edge = q.cfg[`LRD_CFG_ACK_FALL] ? (q.ack_sync[2] & ~q.ack_sync[1])
                                        : (~q.ack_sync[2] & q.ack_sync[1]); // R17

    // manual quit keeps reports until acknowledged; a new event beats the ack
    if (q.cfg[`LRD_CFG_MANQUIT]) begin
      d.latched = (ack_edge ? 7'h00 : q.latched) | live; // R16 R17
    end else begin
      d.latched = 7'h00;
    end
    shown = q.cfg[`LRD_CFG_MANQUIT] ? (q.latched | live) : live;
    d.cond = shown; // R19
    d.hw = q.cfg[`LRD_CFG_MANQUIT] ? (q.hw | hw_fault_in) : hw_fault_in; // R08
    if (q.cfg[`LRD_CFG_MANQUIT] && ack_edge) begin
      d.hw = hw_fault_in;
    end

    // position with zero-point correction and error substitution
    adj_pos = q.cfg[`LRD_CFG_KEEP_OFS] ? 24'(raw_position + q.zero_ofs) : raw_position; // R14
    err_sub = live[`LRD_BIT_INTENSITY] || live[`LRD_BIT_HARDWARE]; // R01 R03
    if (err_sub) begin
      unique case (ev) // R18
        LRD_EV_ONES: d.pos_out = `LRD_ERR_ONES;
        LRD_EV_LAST: d.pos_out = q.last_valid;
        default: d.pos_out = `LRD_ZERO24;
      endcase
    end else begin
      d.pos_out = adj_pos;
      d.last_valid = adj_pos;
    end
    if (!q.cfg[`LRD_CFG_KEEP_OFS]) begin
      d.zero_ofs = `LRD_ZERO24; // R14
    end

    // speed formatting
    scaled = q.cfg[`LRD_CFG_UNIT_1MM] ? speed_abs : 16'(speed_abs / `LRD_DIV10); // R12
    if (q.cfg[`LRD_CFG_SIGNED] && speed_mms[15]) begin
      d.speed_out = 16'(-scaled); // R13
    end else begin
      d.speed_out = scaled;
    end

    // smoothing range: auto picks longer constant at low speed
    if (dyn == LRD_DYN_AUTO) begin
      if (speed_abs < limit_mms[15:0] || speed_abs < `LRD_MMS_PER_STEP) begin
        d.dyn_range = 2'(LRD_DYN_R3); // R11
      end else if (speed_abs < 16'(`LRD_MMS_PER_STEP * `LRD_DIV10)) begin
        d.dyn_range = 2'(LRD_DYN_R2);
      end else begin
        d.dyn_range = 2'(LRD_DYN_R1);
      end
    end else begin
      d.dyn_range = 2'(dyn); // R11
    end

    // switching output function
    unique case (fn)
      LRD_FN_TEMP: fail_raw = shown[`LRD_BIT_TEMP];
      LRD_FN_INTENSITY: fail_raw = shown[`LRD_BIT_INTENSITY];
      LRD_FN_HARDWARE: fail_raw = shown[`LRD_BIT_HARDWARE];
      LRD_FN_EVERY: fail_raw = shown[`LRD_BIT_INTENSITY] | shown[`LRD_BIT_TEMP] | shown[`LRD_BIT_HARDWARE];
      LRD_FN_SPEED: fail_raw = shown[`LRD_BIT_OVERSPEED]; // R10
      LRD_FN_PLAUS: fail_raw = shown[`LRD_BIT_PLAUS];
      LRD_FN_POSITION: fail_raw = pos_switch_hit;
      default: fail_raw = 1'b0;
    endcase
    d.fail_out = fail_raw ^ q.cfg[`LRD_CFG_LEVEL_LOW];

    // interrupt status: set wins over write-one-to-clear
    d.irq_stat = q.irq_stat;
    if (reg_wr && is_addr(reg_addr, `LRD_OFF_IRQ_STAT)) begin
      d.irq_stat = q.irq_stat & ~reg_wdata[6:0];
    end
    d.irq_stat = d.irq_stat | (live & ~q.cond);

    // register writes
    if (reg_wr) begin
      if (is_addr(reg_addr, `LRD_OFF_CFG)) begin
        d.cfg = reg_wdata[`LRD_CFG_W-1:0];
      end
      if (is_addr(reg_addr, `LRD_OFF_THRESH) && (reg_wdata[7:0] <= `LRD_THRESH_MAX)) begin
        d.thresh = reg_wdata[7:0]; // R09
      end
      if (is_addr(reg_addr, `LRD_OFF_PRESET) && q.cfg[`LRD_CFG_KEEP_OFS]) begin
        d.zero_ofs = 24'(reg_wdata[23:0] - raw_position); // R15 R14
      end
      if (is_addr(reg_addr, `LRD_OFF_IRQ_MASK)) begin
        d.irq_mask = reg_wdata[6:0];
      end
      if (is_addr(reg_addr, `LRD_OFF_CTRL)) begin
        d.laser_off_cmd = reg_wdata[`LRD_CTRL_LASER_OFF];
      end
    end

    // register reads, one cycle latency, unmapped reads zero
    d.rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        `LRD_OFF_COND: d.rdata = {25'h0000000, q.cond}; // R19
        `LRD_OFF_HWFAULT: d.rdata = {28'h0000000, q.hw}; // R08
        `LRD_OFF_CFG: d.rdata = {19'h00000, q.cfg};
        `LRD_OFF_THRESH: d.rdata = {24'h000000, q.thresh};
        `LRD_OFF_POSITION: d.rdata = {8'h00, q.pos_out};
        `LRD_OFF_SPEED: d.rdata = {16'h0000, q.speed_out};
        `LRD_OFF_IRQ_STAT: d.rdata = {25'h0000000, q.irq_stat};
        `LRD_OFF_IRQ_MASK: d.rdata = {25'h0000000, q.irq_mask};
        `LRD_OFF_ZERO_OFS: d.rdata = {8'h00, q.zero_ofs};
        `LRD_OFF_CTRL: d.rdata = {31'h00000000, q.laser_off_cmd};
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= '0;
      q.cfg <= `LRD_CFG_RESET;
      q.thresh <= `LRD_THRESH_RESET;
      q.ack_sync <= 3'h0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata = q.rdata;
  assign position_out = q.pos_out;
  assign speed_out = q.speed_out;
  assign dyn_range = q.dyn_range;
  assign laser_emitter_off = q.laser_off_cmd;
  assign fail_out = q.fail_out;
  assign irq = |(q.irq_stat & q.irq_mask);
endmodule

// File: pkg/lrd_regs.svh
// Purpose: register offsets, field positions, reset values and limits of the diagnostics block
// Assumes: 32-bit register port, byte offsets
// Notes: definitions only
`ifndef LRD_REGS_SVH
`define LRD_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define LRD_OFF_COND       8'h00
`define LRD_OFF_HWFAULT    8'h04
`define LRD_OFF_CFG        8'h08
`define LRD_OFF_THRESH     8'h0C
`define LRD_OFF_PRESET     8'h10
`define LRD_OFF_POSITION   8'h14
`define LRD_OFF_SPEED      8'h18
`define LRD_OFF_IRQ_STAT   8'h1C
`define LRD_OFF_IRQ_MASK   8'h20
`define LRD_OFF_ZERO_OFS   8'h24
`define LRD_OFF_CTRL       8'h28

// ****************************************************************
// condition flag positions
// ****************************************************************
`define LRD_BIT_INTENSITY  0
`define LRD_BIT_TEMP       1
`define LRD_BIT_HARDWARE   2
`define LRD_BIT_LASER_OFF  3
`define LRD_BIT_CLEAN      4
`define LRD_BIT_OVERSPEED  5
`define LRD_BIT_PLAUS      6
`define LRD_COND_W         7
`define LRD_HW_W           4

// ****************************************************************
// configuration field positions
// ****************************************************************
`define LRD_CFG_FAILFN_LSB 0
`define LRD_CFG_FAILFN_MSB 2
`define LRD_CFG_LEVEL_LOW  3
`define LRD_CFG_MANQUIT    4
`define LRD_CFG_ERRVAL_LSB 5
`define LRD_CFG_ERRVAL_MSB 6
`define LRD_CFG_DYN_LSB    7
`define LRD_CFG_DYN_MSB    8
`define LRD_CFG_UNIT_1MM   9
`define LRD_CFG_SIGNED     10
`define LRD_CFG_KEEP_OFS   11
`define LRD_CFG_ACK_FALL   12
`define LRD_CFG_W          13
`define LRD_CFG_RESET      13'h0000
`define LRD_CTRL_LASER_OFF 0

// ****************************************************************
// thresholds and limits
// ****************************************************************
`define LRD_INT_ERR_PCT    7'h08
`define LRD_INT_WARN_PCT   7'h0C
`define LRD_TEMP_MIN_C     8'sh00
`define LRD_TEMP_MAX_C     8'sh32
`define LRD_THRESH_MAX     8'hC8
`define LRD_THRESH_RESET   8'h00
`define LRD_MMS_PER_STEP   16'h0064
`define LRD_ERR_ONES       24'hFFFFFF
`define LRD_ZERO24         24'h000000
`define LRD_DIV10          16'h000A

`endif

// File: pkg/lrd_pkg.sv
// Purpose: types shared by the diagnostics block
// Assumes: nothing
// Notes: constants live in lrd_regs.svh
package lrd_pkg;
  typedef enum logic [2:0] {
    LRD_FN_DISABLED, LRD_FN_TEMP, LRD_FN_INTENSITY, LRD_FN_HARDWARE,
    LRD_FN_EVERY, LRD_FN_SPEED, LRD_FN_PLAUS, LRD_FN_POSITION
  } lrd_failfn_e;
  typedef enum logic [1:0] {
    LRD_EV_ZEROS, LRD_EV_ONES, LRD_EV_LAST, LRD_EV_RSVD
  } lrd_errval_e;
  typedef enum logic [1:0] {
    LRD_DYN_AUTO, LRD_DYN_R1, LRD_DYN_R2, LRD_DYN_R3
  } lrd_dyn_e;
  typedef struct packed {
    logic [12:0] cfg;
    logic [7:0] thresh;
    logic [23:0] zero_ofs;
    logic [23:0] last_valid;
    logic [23:0] pos_out;
    logic [15:0] speed_out;
    logic [6:0] latched;
    logic [6:0] cond;
    logic [3:0] hw;
    logic [6:0] irq_stat;
    logic [6:0] irq_mask;
    logic laser_off_cmd;
    logic [2:0] ack_sync;
    logic [31:0] rdata;
    logic fail_out;
    logic [1:0] dyn_range;
  } lrd_state_s;
endpackage

// File: test/lrd_diag_monitor.sv
// Purpose: port assertions for lrd_diag
// Assumes: config mirrored from register writes
// Notes: bound after endmodule
`timescale 1ns/1ps
`include "lrd_regs.svh"
module lrd_diag_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // measurement
  input wire logic [6:0] intensity_pct,
  input wire logic beam_interrupted,
  input wire logic [3:0] hw_fault_in,
  input wire logic [23:0] raw_position,
  input wire logic signed [15:0] speed_mms,
  // outputs
  input wire logic [23:0] position_out,
  input wire logic [15:0] speed_out,
  input wire logic [1:0] dyn_range,
  input wire logic laser_emitter_off,
  input wire logic fail_out
);
  logic [12:0] cfg_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // config mirror, lands one cycle after the write as in the design
  // ****
  always_ff @(posedge core_clk) begin
    if (!reset_n) cfg_q <= `LRD_CFG_RESET;
    else if (reg_wr && reg_addr == `LRD_OFF_CFG) cfg_q <= reg_wdata[12:0];
  end
  a_err_zero: assert property (beam_interrupted && cfg_q[6:5] inside {2'h0, 2'h3}
    |=> position_out == 24'h000000)
    else $error("error value not zero");
  a_err_ones: assert property ((beam_interrupted || hw_fault_in != 4'h0) && cfg_q[6:5] == 2'h1
    |=> position_out == `LRD_ERR_ONES)
    else $error("error value not ones");
  a_pos_raw: assert property (!cfg_q[11] && !beam_interrupted && hw_fault_in == 4'h0
    && intensity_pct >= `LRD_INT_ERR_PCT |=> position_out == $past(raw_position))
    else $error("position not raw");
  a_laser_cmd: assert property (reg_wr && reg_addr == `LRD_OFF_CTRL
    |=> laser_emitter_off == $past(reg_wdata[0]))
    else $error("laser command not applied");
  a_cond_upper: assert property (reg_rd && reg_addr == `LRD_OFF_COND |=> reg_rdata[31:7] == 25'h0000000)
    else $error("unused flag bits set");
  a_speed_ten: assert property (cfg_q[10:9] == 2'h0 && !speed_mms[15]
    |=> speed_out == $past(speed_mms) / 16'sh000A)
    else $error("speed unit wrong");
  a_speed_sgn: assert property (cfg_q[10:9] == 2'h3 |=> speed_out == $past(speed_mms))
    else $error("signed speed wrong");
  a_speed_mag: assert property (cfg_q[10:9] == 2'h1 |=> !speed_out[15])
    else $error("speed magnitude negative");
  a_dyn_fixed: assert property (cfg_q[8:7] != 2'h0 |=> dyn_range == $past(cfg_q[8:7]))
    else $error("fixed range not used");
  a_fail_off: assert property (cfg_q[3:0] == 4'h0 |=> !fail_out)
    else $error("fail output while disabled");
endmodule
bind lrd_diag lrd_diag_monitor mon_u (.*);

// File: test/lrd_host.sv
// Purpose: controller model on the register port
// Assumes: one-cycle strobes, read data the cycle after
// Notes: tasks called by the bench
`timescale 1ns/1ps
module lrd_host (
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // released data is not left looking valid
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// File: test/laser_rangefinder_diagnostics_tb.sv
// Purpose: self-checking bench for lrd_diag
// Assumes: 250 MHz core_clk, host model owns the register port
// Notes: measurement inputs and the ack pin are driven straight from the scenarios
`timescale 1ns/1ps
`include "lrd_regs.svh"
module laser_rangefinder_diagnostics_tb;
  logic core_clk, reset_n, beam_interrupted, laser_off_by_input, plaus_fail, pos_switch_hit, ack_pin, irq;
  logic reg_wr, reg_rd, laser_emitter_off, fail_out;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [6:0] intensity_pct;
  logic signed [7:0] temp_c;
  logic [3:0] hw_fault_in;
  logic [23:0] raw_position, position_out;
  logic signed [15:0] speed_mms;
  logic [15:0] speed_out;
  logic [1:0] dyn_range;
  int fails = 0;
  int n_compared = 0;
  lrd_diag dut_u (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .intensity_pct,
    .beam_interrupted, .temp_c, .hw_fault_in, .laser_off_by_input, .plaus_fail, .raw_position, .speed_mms,
    .pos_switch_hit, .ack_pin, .position_out, .speed_out, .dyn_range, .laser_emitter_off, .fail_out, .irq);
  lrd_host host_u (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ****
  // helpers
  // ****
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic nap();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host_u.rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic cfg(input logic [31:0] v);
    host_u.wr(`LRD_OFF_CFG, v);
    nap();
  endtask
  // bl packs beam cut, laser off input, plausibility fail
  task automatic meas(input logic [6:0] it, input logic [7:0] tp, input logic [3:0] hw, input logic [2:0] bl,
      input logic [15:0] sp);
    @(posedge core_clk);
    intensity_pct <= it;
    temp_c <= tp;
    hw_fault_in <= hw;
    {beam_interrupted, laser_off_by_input, plaus_fail} <= bl;
    speed_mms <= sp;
    nap();
  endtask
  task automatic fl(input string nm, input logic [6:0] it, input logic [7:0] tp, input logic [3:0] hw,
      input logic [2:0] bl, input logic [15:0] sp, input logic [31:0] e);
    meas(it, tp, hw, bl, sp);
    rdc(nm, `LRD_OFF_COND, e);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    meas(7'h32, 8'h19, 4'h0, 3'h0, 16'h0000);
    rdc("cfg rst", `LRD_OFF_CFG, 32'h0);
    rdc("thr rst", `LRD_OFF_THRESH, 32'h0);
    host_u.wr(`LRD_OFF_THRESH, 32'hC9);
    rdc("thr big", `LRD_OFF_THRESH, 32'h0);
    host_u.wr(`LRD_OFF_THRESH, 32'hC8);
    rdc("thr max", `LRD_OFF_THRESH, 32'hC8);
    rdc("unmapped", 8'h3C, 32'h0);
    host_u.wr(`LRD_OFF_COND, 32'h7F);
    rdc("cond ro", `LRD_OFF_COND, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_flags();
    host_u.wr(`LRD_OFF_THRESH, 32'h1);
    fl("int low", 7'h05, 8'h19, 4'h0, 3'h0, 16'h0000, 32'h11);
    fl("beam", 7'h32, 8'h19, 4'h0, 3'h4, 16'h0000, 32'h01);
    fl("clean", 7'h0B, 8'h19, 4'h0, 3'h0, 16'h0000, 32'h10);
    fl("int ok", 7'h0C, 8'h32, 4'h0, 3'h0, 16'h0000, 32'h00);
    fl("hot", 7'h32, 8'h33, 4'h0, 3'h0, 16'h0000, 32'h02);
    fl("cold", 7'h32, 8'hFF, 4'h0, 3'h0, 16'h0000, 32'h02);
    fl("hw", 7'h32, 8'h00, 4'h8, 3'h0, 16'h0000, 32'h04);
    for (int i = 0; i < 4; i++) begin
      meas(7'h32, 8'h19, 4'(1 << i), 3'h0, 16'h0000);
      rdc("hw detail", `LRD_OFF_HWFAULT, 32'(1 << i));
    end
    fl("laser in", 7'h32, 8'h19, 4'h0, 3'h2, 16'h0000, 32'h08);
    fl("plaus", 7'h32, 8'h19, 4'h0, 3'h1, 16'h0000, 32'h40);
    fl("fast", 7'h32, 8'h19, 4'h0, 3'h0, 16'h0065, 32'h20);
    fl("fast rev", 7'h32, 8'h19, 4'h0, 3'h0, 16'hFF9B, 32'h20);
    fl("at limit", 7'h32, 8'h19, 4'h0, 3'h0, 16'h0064, 32'h00);
    host_u.wr(`LRD_OFF_CTRL, 32'h1);
    rdc("laser cmd", `LRD_OFF_COND, 32'h08);
    chk("laser pin", 32'h1, laser_emitter_off);
    host_u.wr(`LRD_OFF_CTRL, 32'h0);
    cfg(32'h5);
    meas(7'h32, 8'h19, 4'h0, 3'h0, 16'h00C8);
    chk("fail spd", 32'h1, fail_out);
    cfg(32'h1);
    chk("fail tmp", 32'h0, fail_out);
    cfg(32'hC);
    chk("fail low", 32'h1, fail_out);
    meas(7'h32, 8'h33, 4'h0, 3'h0, 16'h00C8);
    chk("fail every", 32'h0, fail_out);
    cfg(32'h7);
    @(posedge core_clk);
    pos_switch_hit <= 1'b1;
    nap();
    chk("fail pos", 32'h1, fail_out);
    $display("test flags done");
  endtask
  task automatic t_speed();
    cfg(32'h0);
    meas(7'h32, 8'h19, 4'h0, 3'h0, 16'hFF06);
    chk("spd dflt", 32'h19, speed_out);
    cfg(32'h200);
    chk("spd 1mm", 32'hFA, speed_out);
    cfg(32'h600);
    chk("spd sgn", 32'hFF06, speed_out);
    cfg(32'h400);
    chk("spd sgn10", 32'hFFE7, speed_out);
    cfg(32'h180);
    chk("dyn", 32'h3, dyn_range);
    $display("test speed done");
  endtask
  task automatic t_pos();
    cfg(32'h0);
    meas(7'h32, 8'h19, 4'h0, 3'h0, 16'h0000);
    host_u.wr(`LRD_OFF_PRESET, 32'h3E8);
    nap();
    chk("pos clr", 32'h12C, position_out);
    cfg(32'h800);
    host_u.wr(`LRD_OFF_PRESET, 32'h3E8);
    nap();
    chk("pos adj", 32'h3E8, position_out);
    @(posedge core_clk);
    raw_position <= 24'h000190;
    nap();
    chk("pos move", 32'h44C, position_out);
    cfg(32'h820);
    meas(7'h32, 8'h19, 4'h0, 3'h4, 16'h0000);
    chk("err ones", 32'hFFFFFF, position_out);
    cfg(32'h840);
    chk("err last", 32'h44C, position_out);
    cfg(32'h800);
    chk("err zero", 32'h0, position_out);
    cfg(32'h820);
    meas(7'h32, 8'h19, 4'h2, 3'h0, 16'h0000);
    chk("hw ones", 32'hFFFFFF, position_out);
    cfg(32'h0);
    meas(7'h32, 8'h19, 4'h0, 3'h0, 16'h0000);
    chk("pos raw", 32'h190, position_out);
    $display("test position done");
  endtask
  task automatic t_irq();
    host_u.wr(`LRD_OFF_IRQ_STAT, 32'h7F);
    host_u.wr(`LRD_OFF_IRQ_MASK, 32'h7F);
    meas(7'h32, 8'h19, 4'h0, 3'h1, 16'h0000);
    rdc("irq stat", `LRD_OFF_IRQ_STAT, 32'h40);
    chk("irq on", 32'h1, irq);
    host_u.wr(`LRD_OFF_IRQ_MASK, 32'h0);
    nap();
    chk("irq mask", 32'h0, irq);
    host_u.wr(`LRD_OFF_IRQ_STAT, 32'h40);
    host_u.wr(`LRD_OFF_IRQ_MASK, 32'h7F);
    rdc("irq clr", `LRD_OFF_IRQ_STAT, 32'h0);
    chk("irq low", 32'h0, irq);
    $display("test irq done");
  endtask
  task automatic t_quit();
    cfg(32'h10);
    meas(7'h32, 8'h19, 4'h1, 3'h1, 16'h0000);
    fl("latched", 7'h32, 8'h19, 4'h0, 3'h0, 16'h0000, 32'h44);
    rdc("hw latched", `LRD_OFF_HWFAULT, 32'h1);
    @(posedge core_clk);
    ack_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    rdc("acked", `LRD_OFF_COND, 32'h0);
    rdc("hw acked", `LRD_OFF_HWFAULT, 32'h0);
    cfg(32'h1010);
    meas(7'h32, 8'h19, 4'h0, 3'h1, 16'h0000);
    fl("latched fall", 7'h32, 8'h19, 4'h0, 3'h0, 16'h0000, 32'h40);
    @(posedge core_clk);
    ack_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    rdc("acked fall", `LRD_OFF_COND, 32'h0);
    $display("test quit done");
  endtask
  initial begin
    reset_n = 1'b0;
    {intensity_pct, temp_c, hw_fault_in, speed_mms} = '0;
    {beam_interrupted, laser_off_by_input, plaus_fail, pos_switch_hit, ack_pin} = '0;
    raw_position = 24'h00012C;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_flags();
    t_speed();
    t_pos();
    t_irq();
    t_quit();
    finish_test();
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    finish_test();
  end
endmodule
